// *** rtl/src_defines.svh ***
// Offsets, fields, reset values and timing counts of the controller.
// Assumes a 32-bit AHB-Lite word map and a 50 MHz system clock.
`ifndef SRC_DEFINES_SVH
`define SRC_DEFINES_SVH
// Register word offsets (haddr[7:2])
`define SRC_SLEEP 6'h00
`define SRC_PRR 6'h01
`define SRC_RSTAT 6'h02
`define SRC_RCTRL 6'h03
`define SRC_UNLOCK 6'h04
`define SRC_WDCTRL 6'h05
`define SRC_WDWIN 6'h06
`define SRC_WDSTAT 6'h07
`define SRC_VECT 6'h08
// Sleep mode codes
`define SRC_M_IDLE 3'h0
`define SRC_M_PDOWN 3'h2
`define SRC_M_PSAVE 3'h3
`define SRC_M_STDBY 3'h6
`define SRC_M_ESTDBY 3'h7
// Reset status bit positions
`define SRC_F_POR 0
`define SRC_F_EXT 1
`define SRC_F_BOD 2
`define SRC_F_WDT 3
`define SRC_F_PDI 4
`define SRC_F_SW 5
// Reset values and keys
`define SRC_RST_FLAGS 6'h01
`define SRC_KEY 8'h5A
`define SRC_UNLOCK_WIN 3'h4
`define SRC_RST_STRETCH 3'h4
`define SRC_PER_MAX 4'hA
// Watchdog tick period in us, clock in MHz
`define SRC_TICK_US 1000
`define SRC_CLK_MHZ 50
`endif

// *** rtl/src_pkg.sv ***
// Types of the sleep, reset and watchdog controller.
// Assumes src_defines.svh for all numeric constants.
package src_pkg;
    // Sleep state
    typedef enum logic [0:0] {
        SRC_ACTIVE = 1'b0,
        SRC_ASLEEP = 1'b1
    } src_state_t;

    // Whole controller state
    typedef struct packed {
        src_state_t st;
        logic sleep_en;
        logic [2:0] smode;
        logic [7:0] prr;
        logic boot_vec;
        logic [5:0] flags;
        logic [2:0] unlock;
        logic wd_en;
        logic [3:0] wd_per;
        logic win_en;
        logic [3:0] win_per;
        logic [15:0] div;
        logic [13:0] wd_cnt;
        logic [2:0] int_rst;
        logic wr_pend;
        logic [5:0] waddr;
        logic [31:0] hrdata;
        logic cpu_clk_en;
        logic nvm_clk_en;
        logic [7:0] periph_clk_en;
        logic rtc_clk_en;
        logic osc_en;
    } src_state_s_t;
endpackage : src_pkg

// *** rtl/src_ctrl.sv ***
// Sleep control, reset merging and watchdog with an AHB-Lite slave.
// Assumes synchronous inputs on hclk except the async reset sources.
//
// How it works
// - Idle stops CPU and NVM, any irq wakes
// - Power-down stops all; TWI or port wakes
// - Power-save adds running RTC and RTC wake
// - Standby keeps oscillators, else like power-down
// - Extended standby keeps oscillators, else power-save
// - Sleep only from active; irq/reset wake
// - Power reduction bit gates peripheral clock
// - Reset forces registers to initial values
// - Start at vector 0 or boot start
// - Any reset tri-states ports; pin, supply and debug port resets asynchronously
// - Last reset cause kept in status
// - Held in reset while pin low
// - Supply low resets; brown-out when enabled
// - Watchdog expiry resets when enabled
// - Debug port reset request is a source
// - Software reset only inside unlock window
// - Eleven periods, 8 ms to 8 s
// - Watchdog counts 1 kHz ticks
// - Standard mode: restart before timeout
// - Window mode: restart only inside window
// - Watchdog changes need unlock sequence
// - Always-on fuse keeps watchdog enabled
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "src_defines.svh"
module src_ctrl #(
    parameter int TICK_CYCLES = `SRC_TICK_US * `SRC_CLK_MHZ,
    parameter logic [15:0] BOOT_ADDR = 16'h8000
) (
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset sources
    input wire logic ext_reset_n,
    input wire logic bod_low,
    input wire logic bod_fuse_en,
    input wire logic program_debug_port_rst,
    // Core and wake events
    input wire logic cpu_sleep,
    input wire logic watchdog_restart_instruction,
    input wire logic irq_any,
    input wire logic twi_match_irq,
    input wire logic port_async_irq,
    input wire logic rtc_irq,
    input wire logic rtc_en,
    input wire logic wd_always_on_fuse,
    // Clock gates and reset outputs
    output logic cpu_clk_en,
    output logic nvm_clk_en,
    output logic [7:0] periph_clk_en,
    output logic rtc_clk_en,
    output logic osc_en,
    output logic sys_reset_n,
    output logic port_hiz,
    output logic [15:0] reset_vector
);

    ////////////////////////////////////////////////////////////////
    // State
    src_pkg::src_state_s_t s; // Current state
    src_pkg::src_state_s_t next_s; // Next state
    logic arst_n; // Merged async reset
    logic in_rst; // Block held in reset
    logic tick; // 1 kHz watchdog tick
    logic [13:0] per_ticks; // Open period length
    logic [13:0] win_ticks; // Closed window length
    logic [14:0] limit; // Total timeout, one bit wider
    logic expire; // Watchdog expiry
    logic wake; // Wake event
    logic [31:0] wd; // Write data, hwdata unmasked
    logic [15:0] tick_max; // Divider terminal count

    // Async merge of external sources
    assign arst_n = hresetn & ext_reset_n & ~program_debug_port_rst
        & ~(bod_low & bod_fuse_en);
    assign in_rst = ~sys_reset_n;
    assign tick_max = 16'(TICK_CYCLES - 1);
    assign tick = (s.div == tick_max);

    // Period is 8 ticks shifted by the code
    assign per_ticks = 14'(14'h0008 << s.wd_per);
    assign win_ticks = s.win_en ? 14'(14'h0008 << s.win_per) : 14'h0000;
    // Both at the longest code reach 2^14
    assign limit = 15'({1'b0, per_ticks} + {1'b0, win_ticks});
    assign wd = hwdata;

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_s = s;
        wake = 1'b0;
        expire = 1'b0;
        // Divider for the watchdog tick
        next_s.div = tick ? 16'h0000 : 16'(s.div + 16'h0001);

        // Unlock window countdown
        if (s.unlock != 3'h0)
        begin
            next_s.unlock = 3'(s.unlock - 3'h1);
        end

        // Internal reset stretch countdown
        if (s.int_rst != 3'h0)
        begin
            next_s.int_rst = 3'(s.int_rst - 3'h1);
        end

        // Watchdog count and restart
        if (s.wd_en)
        begin
            if (watchdog_restart_instruction)
            begin
                next_s.wd_cnt = 14'h0000;
                // Restart in closed window is a fault
                if (s.win_en && s.wd_cnt < win_ticks)
                begin
                    expire = 1'b1;
                end
            end
            else if (tick)
            begin
                // Wide compare for the 2^14 span
                if (({1'b0, s.wd_cnt} + 15'h0001) >= limit)
                begin
                    expire = 1'b1;
                    next_s.wd_cnt = 14'h0000;
                end
                else
                begin
                    next_s.wd_cnt = 14'(s.wd_cnt + 14'h0001);
                end
            end
        end
        else
        begin
            next_s.wd_cnt = 14'h0000;
        end

        // Start an internal reset
        if (expire)
        begin
            next_s.int_rst = `SRC_RST_STRETCH;
            next_s.flags[`SRC_F_WDT] = 1'b1;
        end

        // Wake source selection per mode
        unique case (s.smode)
            `SRC_M_IDLE: wake = irq_any;
            `SRC_M_PDOWN, `SRC_M_STDBY:
                wake = twi_match_irq | port_async_irq;
            `SRC_M_PSAVE, `SRC_M_ESTDBY:
                wake = twi_match_irq | port_async_irq
                    | (rtc_irq & rtc_en);
            default: wake = irq_any;
        endcase

        // Sleep state machine
        unique case (s.st)
            src_pkg::SRC_ACTIVE:
            begin
                if (cpu_sleep && s.sleep_en)
                begin
                    next_s.st = src_pkg::SRC_ASLEEP;
                end
            end
            src_pkg::SRC_ASLEEP:
            begin
                if (wake || expire)
                begin
                    next_s.st = src_pkg::SRC_ACTIVE;
                end
            end
        endcase

        // Bus write in data phase
        if (s.wr_pend && !in_rst)
        begin
            unique case (s.waddr)
                `SRC_SLEEP:
                begin
                    next_s.sleep_en = wd[0];
                    next_s.smode = wd[3:1];
                end
                `SRC_PRR: next_s.prr = wd[7:0];
                `SRC_RSTAT:
                begin
                    // Clear old causes, keep ones set now
                    next_s.flags = (s.flags & ~wd[5:0]) | (next_s.flags ^ s.flags);
                end
                `SRC_RCTRL:
                begin
                    if (s.unlock != 3'h0 && wd[0])
                    begin
                        next_s.int_rst = `SRC_RST_STRETCH;
                    end
                end
                `SRC_UNLOCK:
                begin
                    if (wd[7:0] == `SRC_KEY)
                    begin
                        next_s.unlock = `SRC_UNLOCK_WIN;
                    end
                end
                `SRC_WDCTRL:
                begin
                    if (s.unlock != 3'h0 && wd[4:1] <= `SRC_PER_MAX)
                    begin
                        next_s.wd_en = wd[0] | wd_always_on_fuse;
                        next_s.wd_per = wd[4:1];
                        next_s.wd_cnt = 14'h0000;
                    end
                end
                `SRC_WDWIN:
                begin
                    if (s.unlock != 3'h0 && wd[4:1] <= `SRC_PER_MAX)
                    begin
                        next_s.win_en = wd[0];
                        next_s.win_per = wd[4:1];
                    end
                end
                `SRC_VECT: next_s.boot_vec = wd[0];
                default: next_s.prr = next_s.prr;
            endcase
        end

        // Software reset sets its cause after the write above
        if (s.wr_pend && !in_rst && s.waddr == `SRC_RCTRL && s.unlock != 3'h0 && wd[0])
        begin
            next_s.flags[`SRC_F_SW] = 1'b1;
        end

        // Address phase capture
        next_s.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            next_s.wr_pend = hwrite;
            next_s.waddr = haddr[7:2];
            // Read data from the updated state, except the WDSTAT sleep bit, which is taken from the current state
            unique case (haddr[7:2])
                `SRC_SLEEP: next_s.hrdata = {28'h0, next_s.smode, next_s.sleep_en};
                `SRC_PRR: next_s.hrdata = {24'h0, next_s.prr};
                `SRC_RSTAT: next_s.hrdata = {26'h0, next_s.flags};
                `SRC_UNLOCK: next_s.hrdata = {29'h0, next_s.unlock};
                `SRC_WDCTRL: next_s.hrdata = {27'h0, next_s.wd_per, next_s.wd_en};
                `SRC_WDWIN: next_s.hrdata = {27'h0, next_s.win_per, next_s.win_en};
                `SRC_WDSTAT: next_s.hrdata = {17'h0, s.st, next_s.wd_cnt};
                `SRC_VECT: next_s.hrdata = {31'h0, next_s.boot_vec};
                default: next_s.hrdata = 32'h0000_0000;
            endcase
        end

        // Registers forced to initial values during reset
        if (in_rst)
        begin
            next_s.st = src_pkg::SRC_ACTIVE;
            next_s.sleep_en = 1'b0;
            next_s.smode = `SRC_M_IDLE;
            next_s.prr = 8'h00;
            next_s.boot_vec = 1'b0;
            next_s.unlock = 3'h0;
            next_s.wd_en = wd_always_on_fuse;
            next_s.wd_per = `SRC_PER_MAX;
            next_s.win_en = 1'b0;
            next_s.win_per = 4'h0;
            next_s.wd_cnt = 14'h0000;
            next_s.wr_pend = 1'b0;
        end

        // Always-on fuse overrides any disable
        if (wd_always_on_fuse)
        begin
            next_s.wd_en = 1'b1;
        end

        // Cause capture, set wins over clear
        if (!ext_reset_n)
        begin
            next_s.flags[`SRC_F_EXT] = 1'b1;
        end
        if (bod_low && bod_fuse_en)
        begin
            next_s.flags[`SRC_F_BOD] = 1'b1;
        end
        if (program_debug_port_rst)
        begin
            next_s.flags[`SRC_F_PDI] = 1'b1;
        end

        // Clock gates per mode
        next_s.cpu_clk_en = 1'b1;
        next_s.nvm_clk_en = 1'b1;
        next_s.periph_clk_en = ~next_s.prr;
        next_s.rtc_clk_en = rtc_en;
        next_s.osc_en = 1'b1;
        if (next_s.st == src_pkg::SRC_ASLEEP)
        begin
            next_s.cpu_clk_en = 1'b0;
            next_s.nvm_clk_en = 1'b0;
            if (next_s.smode != `SRC_M_IDLE)
            begin
                next_s.periph_clk_en = 8'h00;
                // RTC runs only in the save modes
                next_s.rtc_clk_en = rtc_en && (next_s.smode == `SRC_M_PSAVE
                    || next_s.smode == `SRC_M_ESTDBY);
                // Oscillators kept only in standby modes
                next_s.osc_en = next_s.smode[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register, power-on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.flags <= `SRC_RST_FLAGS;
            s.wd_per <= `SRC_PER_MAX;
            s.cpu_clk_en <= 1'b1;
            s.nvm_clk_en <= 1'b1;
            s.periph_clk_en <= 8'hFF;
            s.osc_en <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Reset output, asserted with no clock by external sources, on an hclk edge by internal ones
    always_ff @(posedge hclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_reset_n <= 1'b0;
            port_hiz <= 1'b1;
        end
        else
        begin
            sys_reset_n <= (s.int_rst == 3'h0);
            port_hiz <= (s.int_rst != 3'h0);
        end
    end

    // Bus response tied off, other outputs from state flops
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign cpu_clk_en = s.cpu_clk_en;
    assign nvm_clk_en = s.nvm_clk_en;
    assign periph_clk_en = s.periph_clk_en;
    assign rtc_clk_en = s.rtc_clk_en;
    assign osc_en = s.osc_en;
    assign reset_vector = s.boot_vec ? BOOT_ADDR : 16'h0000;

endmodule : src_ctrl

// *** verification/src_ctrl_asserts.sv ***
// Port checker of the sleep, reset and watchdog controller.
// Assumes binding onto src_ctrl and a single hclk domain.
`timescale 1ns/1ps
module src_ctrl_asserts #(
    parameter logic [15:0] BOOT_ADDR = 16'h8000
) (
    // Clock and reset sources
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ext_reset_n,
    input wire logic bod_low,
    input wire logic bod_fuse_en,
    input wire logic program_debug_port_rst,
    // Core and wake inputs
    input wire logic cpu_sleep,
    input wire logic twi_match_irq,
    // Watched outputs
    input wire logic cpu_clk_en,
    input wire logic nvm_clk_en,
    input wire logic [7:0] periph_clk_en,
    input wire logic osc_en,
    input wire logic sys_reset_n,
    input wire logic port_hiz,
    input wire logic [15:0] reset_vector
);
    // One clock domain
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    // No outside reset source active
    logic src_quiet;
    assign src_quiet = ext_reset_n && !program_debug_port_rst && !(bod_low && bod_fuse_en);
    ////////////////////////////////////////
    property p_ext; !ext_reset_n |-> !sys_reset_n && port_hiz; endproperty
    a_ext: assert property (p_ext) else $error("pin reset not held");
    property p_pdi; program_debug_port_rst |-> !sys_reset_n && port_hiz; endproperty
    a_pdi: assert property (p_pdi) else $error("debug reset not taken");
    property p_bod; bod_low && bod_fuse_en |-> !sys_reset_n; endproperty
    a_bod: assert property (p_bod) else $error("supply low not reset");
    property p_hiz; !sys_reset_n |-> port_hiz; endproperty
    a_hiz: assert property (p_hiz) else $error("ports driven in reset");
    property p_vec; reset_vector == 16'h0000 || reset_vector == BOOT_ADDR; endproperty
    a_vec: assert property (p_vec) else $error("bad reset vector");
    property p_nvm; nvm_clk_en == cpu_clk_en; endproperty
    a_nvm: assert property (p_nvm) else $error("memory clock apart from cpu");
    property p_osc; !osc_en |-> !cpu_clk_en && periph_clk_en == 8'h00; endproperty
    a_osc: assert property (p_osc) else $error("clocks run without source");
    property p_stop; $fell(cpu_clk_en) |-> $past(cpu_sleep); endproperty
    a_stop: assert property (p_stop) else $error("cpu stopped unasked");
    property p_wake;
        !cpu_clk_en && periph_clk_en == 8'h00 && twi_match_irq |-> ##[1:3] cpu_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("address match did not wake");
    property p_stretch; $fell(sys_reset_n) && src_quiet |-> !sys_reset_n [*4] ##1 sys_reset_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("internal reset length");
    // Main scenarios
    c_int_rst: cover property ($fell(sys_reset_n) && src_quiet);
    c_sleep: cover property ($fell(cpu_clk_en));
    c_wake: cover property ($rose(cpu_clk_en));
endmodule : src_ctrl_asserts

bind src_ctrl src_ctrl_asserts #(.BOOT_ADDR(BOOT_ADDR)) u_src_ctrl_asserts (
    .hclk(hclk), .hresetn(hresetn), .ext_reset_n(ext_reset_n), .bod_low(bod_low),
    .bod_fuse_en(bod_fuse_en), .program_debug_port_rst(program_debug_port_rst),
    .cpu_sleep(cpu_sleep), .twi_match_irq(twi_match_irq), .cpu_clk_en(cpu_clk_en),
    .nvm_clk_en(nvm_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .sys_reset_n(sys_reset_n), .port_hiz(port_hiz), .reset_vector(reset_vector));

// *** verification/src_core_model.sv ***
// Core, peripheral and debug port side of the controller.
// Assumes its tasks are entered just after a rising edge.
`timescale 1ns/1ps
module src_core_model (
    // Clock and device status
    input wire logic hclk,
    input wire logic cpu_clk_en,
    input wire logic sys_reset_n,
    // Core instruction pulses
    output logic cpu_sleep,
    output logic watchdog_restart_instruction,
    // Debug port and peripherals
    output logic program_debug_port_rst,
    output logic irq_any,
    output logic twi_match_irq,
    output logic port_async_irq,
    output logic rtc_irq,
    output logic rtc_en
);
    // Quiet at power-up, counter enabled
    initial
    begin
        {cpu_sleep, watchdog_restart_instruction, program_debug_port_rst} = 3'h0;
        {irq_any, twi_match_irq, port_async_irq, rtc_irq} = 4'h0;
        rtc_en = 1'h1;
    end
    // Only a running core issues sleep or restart
    task automatic run_pulse(input logic restart);
        while (cpu_clk_en !== 1'h1 || sys_reset_n !== 1'h1)
            @(posedge hclk);
        cpu_sleep <= !restart;
        watchdog_restart_instruction <= restart;
        @(posedge hclk);
        cpu_sleep <= 1'h0;
        watchdog_restart_instruction <= 1'h0;
    endtask : run_pulse
    // Peripheral wake levels
    task automatic set_wake(input logic [4:0] lines);
        {rtc_en, irq_any, twi_match_irq, port_async_irq, rtc_irq} <= lines ^ 5'h10;
    endtask : set_wake
    // Debug port reset request level
    task automatic set_debug(input logic on);
        program_debug_port_rst <= on;
    endtask : set_debug
endmodule : src_core_model

// *** verification/src_ctrl_tb.sv ***
// Self-checking bench of the sleep, reset and watchdog controller.
// Assumes src_core_model on the core side and a short watchdog tick.
`timescale 1ns/1ps
`include "src_defines.svh"
module src_ctrl_tb;
    localparam logic [15:0] BOOT = 16'h8000;
    // Bus, board and core signals
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ext_reset_n, bod_low, bod_fuse_en, wd_always_on_fuse, sys_reset_n, port_hiz;
    logic cpu_sleep, restart, pdi_rst, irq_any, twi_irq, port_irq, rtc_irq, rtc_en;
    logic cpu_clk_en, nvm_clk_en, rtc_clk_en, osc_en;
    logic [7:0] periph_clk_en;
    logic [15:0] reset_vector;
    logic [11:0] gates;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    // Per sleep mode: code, clock gates, false and true wake lines
    logic [2:0] modes[5] = '{`SRC_M_IDLE, `SRC_M_PDOWN, `SRC_M_PSAVE, `SRC_M_STDBY, `SRC_M_ESTDBY};
    logic [11:0] gate[5] = '{12'h3EB, 12'h000, 12'h002, 12'h001, 12'h003};
    logic [4:0] bad[5] = '{5'h00, 5'h09, 5'h19, 5'h09, 5'h19};
    logic [4:0] good[5] = '{5'h08, 5'h04, 5'h01, 5'h02, 5'h01};
    int cause[3] = '{`SRC_F_EXT, `SRC_F_PDI, `SRC_F_BOD};
    assign gates = {cpu_clk_en, nvm_clk_en, periph_clk_en, rtc_clk_en, osc_en};
    ////////////////////////////////////////
    src_ctrl #(.TICK_CYCLES(8), .BOOT_ADDR(BOOT)) u_src_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset_n(ext_reset_n),
        .bod_low(bod_low), .bod_fuse_en(bod_fuse_en), .program_debug_port_rst(pdi_rst),
        .cpu_sleep(cpu_sleep), .watchdog_restart_instruction(restart), .irq_any(irq_any),
        .twi_match_irq(twi_irq), .port_async_irq(port_irq), .rtc_irq(rtc_irq),
        .rtc_en(rtc_en), .wd_always_on_fuse(wd_always_on_fuse), .cpu_clk_en(cpu_clk_en),
        .nvm_clk_en(nvm_clk_en), .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en),
        .osc_en(osc_en), .sys_reset_n(sys_reset_n), .port_hiz(port_hiz),
        .reset_vector(reset_vector));
    src_core_model u_src_core_model (
        .hclk(hclk), .cpu_clk_en(cpu_clk_en), .sys_reset_n(sys_reset_n),
        .cpu_sleep(cpu_sleep), .watchdog_restart_instruction(restart),
        .program_debug_port_rst(pdi_rst), .irq_any(irq_any), .twi_match_irq(twi_irq),
        .port_async_irq(port_irq), .rtc_irq(rtc_irq), .rtc_en(rtc_en));
    // 50 MHz clock
    initial
    begin
        hclk = 1'h0;
        forever #10 hclk = ~hclk;
    end
    ////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Single word bus transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : xfer
    // Protected write behind the key
    task automatic unlock_wr(input logic [5:0] idx, input logic [31:0] wd);
        xfer(1'h1, `SRC_UNLOCK, {24'h0, `SRC_KEY});
        xfer(1'h1, idx, wd);
    endtask : unlock_wr
    // Edge counting helpers
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask : cyc
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (sys_reset_n !== lvl && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
    endtask : wait_rst
    // Read a status word and clear it
    task automatic cause_is(input int bit_pos);
        xfer(1'h0, `SRC_RSTAT, 32'h0);
        check("cause", rd, 32'h1 << bit_pos);
        xfer(1'h1, `SRC_RSTAT, 32'h3F);
    endtask : cause_is
    ////////////////////////////////////////
    // Power-up values, unmapped place, vector move
    task automatic t_regs();
        cause_is(`SRC_F_POR);
        xfer(1'h0, `SRC_WDCTRL, 32'h0);
        check("wd_ctrl", rd, 32'h14);
        xfer(1'h0, 6'h09, 32'h0);
        check("unmapped", rd, 32'h0);
        check("gates", {20'h0, gates}, 32'hFFF);
        check("vector", {16'h0, reset_vector}, 32'h0);
        xfer(1'h1, `SRC_VECT, 32'h1);
        cyc(1);
        check("vector", {16'h0, reset_vector}, {16'h0, BOOT});
        xfer(1'h1, `SRC_VECT, 32'h0);
    endtask : t_regs
    // Pin, debug port and supply resets act without a clock edge
    task automatic t_src();
        for (int i = 0; i < 3; i++)
        begin
            if (i == 0)
                ext_reset_n <= 1'h0;
            else if (i == 1)
                u_src_core_model.set_debug(1'h1);
            else
                bod_low <= 1'h1;
            #1;
            check("async", {30'h0, sys_reset_n, port_hiz}, 32'h1);
            cyc(3);
            ext_reset_n <= 1'h1;
            u_src_core_model.set_debug(1'h0);
            bod_low <= 1'h0;
            wait_rst(1'h1, 8);
            cause_is(cause[i]);
        end
        bod_fuse_en <= 1'h0;
        bod_low <= 1'h1;
        cyc(4);
        check("bod_off", {31'h0, sys_reset_n}, 32'h1);
        bod_low <= 1'h0;
        bod_fuse_en <= 1'h1;
    endtask : t_src
    // Gating, all five modes, wrong and right wake sources
    task automatic t_sleep();
        xfer(1'h1, `SRC_PRR, 32'h05);
        cyc(1);
        check("prr", {24'h0, periph_clk_en}, 32'hFA);
        for (int m = 0; m < 5; m++)
        begin
            xfer(1'h1, `SRC_SLEEP, {28'h0, modes[m], 1'h1});
            u_src_core_model.run_pulse(1'h0);
            cyc(3);
            check("sleep_gates", {20'h0, gates}, {20'h0, gate[m]});
            u_src_core_model.set_wake(bad[m]);
            cyc(4);
            check("no_wake", {31'h0, cpu_clk_en}, 32'h0);
            u_src_core_model.set_wake(good[m]);
            cyc(4);
            check("wake", {31'h0, cpu_clk_en}, 32'h1);
            u_src_core_model.set_wake(5'h00);
        end
        xfer(1'h1, `SRC_SLEEP, {28'h0, `SRC_M_PDOWN, 1'h0});
        u_src_core_model.run_pulse(1'h0);
        cyc(4);
        check("no_sleep", {31'h0, cpu_clk_en}, 32'h1);
    endtask : t_sleep
    // Software reset refused, then taken behind the key
    task automatic t_soft();
        xfer(1'h1, `SRC_RCTRL, 32'h1);
        cyc(6);
        check("locked", {31'h0, sys_reset_n}, 32'h1);
        unlock_wr(`SRC_RCTRL, 32'h1);
        wait_rst(1'h0, 8);
        wait_rst(1'h1, 8);
        xfer(1'h0, `SRC_PRR, 32'h0);
        check("prr_reset", rd, 32'h0);
        cause_is(`SRC_F_SW);
    endtask : t_soft
    // Lock, bad period, feeding, expiry, window, always-on
    task automatic t_wd();
        xfer(1'h1, `SRC_WDCTRL, 32'h1);
        unlock_wr(`SRC_WDCTRL, 32'h17);
        xfer(1'h0, `SRC_WDCTRL, 32'h0);
        check("wd_refused", rd, 32'h14);
        unlock_wr(`SRC_WDCTRL, 32'h1);
        repeat (4)
        begin
            cyc(40);
            u_src_core_model.run_pulse(1'h1);
        end
        check("fed", {31'h0, sys_reset_n}, 32'h1);
        wait_rst(1'h0, 200);
        check("timeout", {31'h0, n >= 56 && n <= 72}, 32'h1);
        wait_rst(1'h1, 8);
        cause_is(`SRC_F_WDT);
        unlock_wr(`SRC_WDCTRL, 32'h1);
        unlock_wr(`SRC_WDWIN, 32'h1);
        cyc(90);
        u_src_core_model.run_pulse(1'h1);
        cyc(8);
        check("in_window", {31'h0, sys_reset_n}, 32'h1);
        u_src_core_model.run_pulse(1'h1);
        wait_rst(1'h0, 8);
        check("early", {31'h0, sys_reset_n}, 32'h0);
        wait_rst(1'h1, 8);
        wd_always_on_fuse <= 1'h1;
        unlock_wr(`SRC_WDCTRL, 32'h1);
        unlock_wr(`SRC_WDCTRL, 32'h0);
        wait_rst(1'h0, 120);
        check("always_on", {31'h0, sys_reset_n}, 32'h0);
        wd_always_on_fuse <= 1'h0;
        wait_rst(1'h1, 8);
    endtask : t_wd
    ////////////////////////////////////////
    // Verdict and end of run
    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // Main sequence
    initial
    begin
        {hresetn, hsel, hwrite, bod_low, wd_always_on_fuse} = 5'h0;
        {ext_reset_n, bod_fuse_en} = 2'h3;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        cyc(12);
        hresetn <= 1'h1;
        cyc(2);
        t_regs();
        t_src();
        t_sleep();
        t_soft();
        t_wd();
        print_verdict();
    end
    // Hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule : src_ctrl_tb
